/* File: hdl/pvi_defines.svh */
`ifndef PVI_DEFINES_SVH
`define PVI_DEFINES_SVH

// Source counts
`define PVI_NUM_MASKABLE   11
`define PVI_NUM_EXT_PINS   3
`define PVI_NUM_KEY_PINS   8

// Priority slots of the maskable sources
`define PVI_PRIO_WDT       4'd0
`define PVI_PRIO_EXT0      4'd1
`define PVI_PRIO_SERIAL_RX 4'd4
`define PVI_PRIO_TX        4'd5
`define PVI_PRIO_WATCH     4'd6
`define PVI_PRIO_WATCH_IV  4'd7
`define PVI_PRIO_TIMER8    4'd8
`define PVI_PRIO_TIMER16   4'd9
`define PVI_PRIO_KEY       4'd10

// Vector table
`define PVI_VEC_NMI        16'h0004
`define PVI_VEC_BASE       16'h0004
`define PVI_VEC_EXT0       16'h0006
`define PVI_VEC_SERIAL_RX  16'h000c
`define PVI_VEC_KEY        16'h0018

// Register offsets
`define PVI_REG_FLAG_LO    4'h0
`define PVI_REG_FLAG_HI    4'h1
`define PVI_REG_MASK_LO    4'h2
`define PVI_REG_MASK_HI    4'h3
`define PVI_REG_EDGE_SEL   4'h4
`define PVI_REG_KEY_MODE   4'h5
`define PVI_REG_PSW        4'h6
`define PVI_REG_CTRL       4'h7

// Field positions
`define PVI_PSW_IE_BIT     3'd7
`define PVI_CTRL_NMI_MODE  3'd0
`define PVI_CTRL_NMI_ACT   3'd1

// Edge select codes, two bits per pin
`define PVI_EDGE_FALL      2'h0
`define PVI_EDGE_RISE      2'h1

// Reset values
`define PVI_RST_MASK       11'h7ff
`define PVI_RST_EDGE_SEL   6'h00
`define PVI_RST_KEY_MODE   8'h00
`define PVI_RST_PSW        8'h00
`define PVI_RST_NMI_MODE   1'b0

`endif

/* File: hdl/pvi_pkg.sv */
package pvi_pkg;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic       irq_ack;
		logic       nmi_ack;
		logic       return_from_irq;
		logic [7:0] restored_psw;
	} core_ctl_t;

	typedef struct packed {
		logic       watchdog_overflow_irq;
		logic       async_rx_done_irq;
		logic       sync_serial_done_irq;
		logic       async_tx_done_irq;
		logic       watch_tick_irq;
		logic       watch_interval_irq;
		logic       timer8_match_irq;
		logic       timer16_match_irq;
	} periph_evt_t;

endpackage : pvi_pkg

/* File: hdl/prioritized_vectored_interrupts.sv */
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pvi_defines.svh"

// Overview of operation
// - Twelve sources: one non-maskable and eleven maskable.
// - Among pending maskable requests the smallest priority number is served.
// - Watchdog-mode overflow raises the non-maskable request, vector 0004H.
// - Interval-mode watchdog overflow raises maskable priority 0 request.
// - Three edge pins are maskable priorities 1 to 3; first vectors 0006H.
// - Async receive and sync transfer share priority 4, vector 000CH.
// - Async transmit completion raises its own maskable request, priority 5.
// - 8-bit timer match is priority 8, 16-bit timer match priority 9.
// - Key return detection raises lowest priority 10 request, vector 0018H.
// - A flag shows a non-maskable interrupt is being serviced until return.
// - Status word holds a global enable that gates maskable requests.
// - Each edge pin triggers on selected rising, falling or both edges.
// - On return, status word restored and non-maskable flag cleared.
module prioritized_vectored_interrupts (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	// Register port
	input  wire pvi_pkg::reg_req_t    bus_req,
	output logic [7:0]                reg_rdata,
	// Peripheral events, one-cycle pulses
	input  wire pvi_pkg::periph_evt_t periph_evt,
	// Pins
	input  wire logic [2:0]           ext_edge_irqs,
	input  wire logic [7:0]           key_return_n,
	// Processor core
	input  wire pvi_pkg::core_ctl_t   core_ctl,
	output logic                      irq_req,
	output logic [15:0]               irq_vector,
	output logic                      nmi_req,
	output logic [7:0]                processor_status_word,
	output logic                      nonmaskable_active,
	output logic                      irq_level
);

	//////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, a change counts when two agree

	logic [10:0] s1;
	logic [10:0] s2;
	logic [10:0] s3;
	logic [10:0] stable;
	logic [10:0] next_stable;
	logic [10:0] rise;
	logic [10:0] fall;

	always_comb begin
		next_stable = stable;
		rise        = '0;
		fall        = '0;
		for (int i = 0; i < 11; i++) begin
			if (s2[i] == s3[i] && s3[i] != stable[i]) begin
				next_stable[i] = s3[i];
				rise[i]        = s3[i];
				fall[i]        = ~s3[i];
			end
		end
	end

	// Pins idle high: pulled up inputs
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s1     <= 11'h7ff;
			s2     <= 11'h7ff;
			s3     <= 11'h7ff;
			stable <= 11'h7ff;
		end else begin
			s1     <= {key_return_n, ext_edge_irqs};
			s2     <= s1;
			s3     <= s2;
			stable <= next_stable;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Registers

	logic [10:0] flag;
	logic [10:0] irq_mask_bit;
	logic [3:0]  serve_idx;
	logic [5:0]  ext_edge_select_reg;
	logic [7:0]  key_return_mode_reg;
	logic        nmi_mode;
	logic [10:0] next_flag;
	logic [10:0] next_mask;
	logic [5:0]  next_edge_sel;
	logic [7:0]  next_key_mode;
	logic        next_nmi_mode;
	logic [7:0]  next_psw;
	logic        next_nmi_act;
	logic        next_nmi_req;
	logic [7:0]  next_rdata;
	logic [10:0] src_set;
	logic [10:0] clr;
	logic        global_irq_enable;

	assign global_irq_enable = processor_status_word[`PVI_PSW_IE_BIT];

	function automatic logic edge_hit(input logic [1:0] sel,
		input logic r, input logic f);
		case (sel)
			`PVI_EDGE_FALL: edge_hit = f;
			`PVI_EDGE_RISE: edge_hit = r;
			default:        edge_hit = r | f;
		endcase
	endfunction : edge_hit

	function automatic logic wr_hit(input pvi_pkg::reg_req_t q,
		input logic [3:0] a);
		wr_hit = q.wr && q.addr == a;
	endfunction : wr_hit

	always_comb begin
		src_set = '0;
		src_set[`PVI_PRIO_WDT] = periph_evt.watchdog_overflow_irq & ~nmi_mode;
		for (int i = 0; i < 3; i++)
			src_set[i + 1] = edge_hit(ext_edge_select_reg[2*i +: 2],
				rise[i], fall[i]);
		src_set[`PVI_PRIO_SERIAL_RX] = periph_evt.async_rx_done_irq
			| periph_evt.sync_serial_done_irq;
		src_set[`PVI_PRIO_TX]       = periph_evt.async_tx_done_irq;
		src_set[`PVI_PRIO_WATCH]    = periph_evt.watch_tick_irq;
		src_set[`PVI_PRIO_WATCH_IV] = periph_evt.watch_interval_irq;
		src_set[`PVI_PRIO_TIMER8]   = periph_evt.timer8_match_irq;
		src_set[`PVI_PRIO_TIMER16]  = periph_evt.timer16_match_irq;
		src_set[`PVI_PRIO_KEY] = |(fall[10:3] & key_return_mode_reg);
	end

	always_comb begin
		clr = '0;
		if (wr_hit(bus_req, `PVI_REG_FLAG_LO))
			clr[7:0] = bus_req.wdata;
		if (wr_hit(bus_req, `PVI_REG_FLAG_HI))
			clr[10:8] = bus_req.wdata[2:0];
		if (core_ctl.irq_ack && irq_req)
			clr[serve_idx] = 1'b1;
		next_flag = (flag & ~clr) | src_set;
		next_mask = irq_mask_bit;
		if (wr_hit(bus_req, `PVI_REG_MASK_LO))
			next_mask[7:0] = bus_req.wdata;
		if (wr_hit(bus_req, `PVI_REG_MASK_HI))
			next_mask[10:8] = bus_req.wdata[2:0];
		next_edge_sel = wr_hit(bus_req, `PVI_REG_EDGE_SEL) ?
			bus_req.wdata[5:0] : ext_edge_select_reg;
		next_key_mode = wr_hit(bus_req, `PVI_REG_KEY_MODE) ?
			bus_req.wdata : key_return_mode_reg;
		next_nmi_mode = wr_hit(bus_req, `PVI_REG_CTRL) ?
			bus_req.wdata[`PVI_CTRL_NMI_MODE] : nmi_mode;
		next_psw = wr_hit(bus_req, `PVI_REG_PSW) ?
			bus_req.wdata : processor_status_word;
		// Acceptance masks further maskable requests
		if (core_ctl.irq_ack && irq_req)
			next_psw[`PVI_PSW_IE_BIT] = 1'b0;
		if (core_ctl.return_from_irq)
			next_psw = core_ctl.restored_psw;
		next_nmi_act = nonmaskable_active;
		if (core_ctl.return_from_irq)
			next_nmi_act = 1'b0;
		if (core_ctl.nmi_ack && nmi_req)
			next_nmi_act = 1'b1;
		next_nmi_req = nmi_req && !core_ctl.nmi_ack;
		if (periph_evt.watchdog_overflow_irq && nmi_mode)
			next_nmi_req = 1'b1;
		next_rdata = 8'h00;
		if (bus_req.rd) begin
			case (bus_req.addr)
				`PVI_REG_FLAG_LO:  next_rdata = flag[7:0];
				`PVI_REG_FLAG_HI:  next_rdata = {5'h00, flag[10:8]};
				`PVI_REG_MASK_LO:  next_rdata = irq_mask_bit[7:0];
				`PVI_REG_MASK_HI:  next_rdata = {5'h00, irq_mask_bit[10:8]};
				`PVI_REG_EDGE_SEL: next_rdata = {2'h0, ext_edge_select_reg};
				`PVI_REG_KEY_MODE: next_rdata = key_return_mode_reg;
				`PVI_REG_PSW:      next_rdata = processor_status_word;
				`PVI_REG_CTRL:
					next_rdata = {6'h00, nonmaskable_active, nmi_mode};
				default:           next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			flag                  <= '0;
			irq_mask_bit          <= `PVI_RST_MASK;
			ext_edge_select_reg   <= `PVI_RST_EDGE_SEL;
			key_return_mode_reg   <= `PVI_RST_KEY_MODE;
			nmi_mode              <= `PVI_RST_NMI_MODE;
			processor_status_word <= `PVI_RST_PSW;
			nonmaskable_active    <= 1'b0;
			nmi_req               <= 1'b0;
			reg_rdata             <= 8'h00;
		end else begin
			flag                  <= next_flag;
			irq_mask_bit          <= next_mask;
			ext_edge_select_reg   <= next_edge_sel;
			key_return_mode_reg   <= next_key_mode;
			nmi_mode              <= next_nmi_mode;
			processor_status_word <= next_psw;
			nonmaskable_active    <= next_nmi_act;
			nmi_req               <= next_nmi_req;
			reg_rdata             <= next_rdata;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Priority resolution and vector

	logic [10:0] pend;
	logic [3:0]  next_idx;
	logic        next_req;
	logic [15:0] next_vector;
	logic [10:0] pend_q;

	assign pend      = flag & ~irq_mask_bit;
	assign irq_level = |pend;

	always_comb begin
		next_idx = 4'd0;
		for (int i = 10; i >= 0; i--)
			if (pend[i])
				next_idx = 4'(i);
		// global enable gates the core request
		next_req = |pend && global_irq_enable
			&& !(core_ctl.irq_ack && irq_req);
		// Vectors step by two bytes per slot
		next_vector = `PVI_VEC_BASE + {11'h000, next_idx, 1'b0};
		if (next_idx >= `PVI_PRIO_SERIAL_RX && next_idx <= `PVI_PRIO_TX)
			next_vector = `PVI_VEC_SERIAL_RX
				+ {11'h000, next_idx - `PVI_PRIO_SERIAL_RX, 1'b0};
		if (next_idx >= `PVI_PRIO_EXT0 && next_idx < `PVI_PRIO_SERIAL_RX)
			next_vector = `PVI_VEC_EXT0
				+ {11'h000, next_idx - `PVI_PRIO_EXT0, 1'b0};
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_req    <= 1'b0;
			serve_idx  <= 4'd0;
			irq_vector <= `PVI_VEC_NMI;
			pend_q     <= '0;
		end else begin
			irq_req    <= next_req;
			serve_idx  <= next_idx;
			irq_vector <= nmi_req ? `PVI_VEC_NMI : next_vector;
			pend_q     <= pend;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_nmi_raise: assert property (
		periph_evt.watchdog_overflow_irq && nmi_mode |=> nmi_req
		##1 irq_vector == 16'h0004)
		else $error("watchdog overflow did not raise non-maskable");
	a_wdt_maskable: assert property (
		periph_evt.watchdog_overflow_irq && !nmi_mode
		|=> flag[0] && (!nmi_req || $past(nmi_req)))
		else $error("interval overflow did not set slot 0");
	a_prio_lowest: assert property (
		irq_req |-> pend_q[serve_idx] && (pend_q & ((11'h001 << serve_idx)
		- 11'h001)) == 11'h000)
		else $error("served request is not highest priority");
	a_gate_enable: assert property (
		irq_req |-> $past(global_irq_enable) && $past(|pend))
		else $error("request forwarded while disabled or masked");
	a_ack_clear: assert property (
		core_ctl.irq_ack && irq_req && !src_set[serve_idx]
		|=> !flag[$past(serve_idx)] && !global_irq_enable)
		else $error("acknowledge left flag or enable set");
	a_serial_share: assert property (
		periph_evt.sync_serial_done_irq |=> flag[4])
		else $error("serial transfer did not set shared slot");
	a_nmi_service: assert property (
		core_ctl.nmi_ack && nmi_req && !core_ctl.return_from_irq
		|=> nonmaskable_active)
		else $error("service flag not set on acceptance");
	a_return_restore: assert property (
		core_ctl.return_from_irq && !core_ctl.nmi_ack |=> !nonmaskable_active
		&& processor_status_word == $past(core_ctl.restored_psw))
		else $error("return did not restore status");

	c_nmi_served: cover property (nmi_req && core_ctl.nmi_ack
		##[1:20] core_ctl.return_from_irq);
	c_two_pending: cover property (irq_req && $countones(pend_q) > 1);
	c_key_vector: cover property (irq_req && irq_vector == 16'h0018);

endmodule : prioritized_vectored_interrupts
`default_nettype wire

/* File: bench/pvi_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module pvi_core_model (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// Controller side
	input  wire logic             irq_req,
	input  wire logic             nmi_req,
	input  wire logic [7:0]       processor_status_word,
	// Cycles to wait before taking a request
	input  wire logic [3:0]       delay,
	output var  pvi_pkg::core_ctl_t core_ctl
);
	logic [3:0]         wait_cnt;
	logic [3:0]         ret_cnt;
	logic               busy;
	logic [7:0]         saved_psw;
	pvi_pkg::core_ctl_t ctl;

	// One handler at a time; nesting is not modelled
	always @(posedge ref_clk) begin
		ctl = '0;
		if (!rst_n) begin
			busy     <= 1'b0;
			wait_cnt <= 4'h0;
			ret_cnt  <= 4'h0;
		end else if (busy) begin
			ret_cnt <= ret_cnt + 4'h1;
			if (ret_cnt == 4'h8) begin
				ctl.return_from_irq = 1'b1;
				ctl.restored_psw    = saved_psw;
				busy                <= 1'b0;
			end
		end else if (irq_req || nmi_req) begin
			if (wait_cnt >= delay) begin
				ctl.nmi_ack = nmi_req;
				ctl.irq_ack = !nmi_req;
				saved_psw   <= processor_status_word;
				busy        <= 1'b1;
				wait_cnt    <= 4'h0;
				ret_cnt     <= 4'h0;
			end else begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end
		// One update of the handshake per edge
		core_ctl <= ctl;
	end
endmodule : pvi_core_model
`default_nettype wire

/* File: bench/tb_prioritized_vectored_interrupts.sv */
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module tb_prioritized_vectored_interrupts;
	logic                 ref_clk;
	logic                 rst_n;
	pvi_pkg::reg_req_t    bus_req;
	logic [7:0]           reg_rdata;
	pvi_pkg::periph_evt_t periph_evt;
	logic [2:0]           ext_edge_irqs;
	logic [7:0]           key_return_n;
	pvi_pkg::core_ctl_t   core_ctl;
	logic                 irq_req;
	logic [15:0]          irq_vector;
	logic                 nmi_req;
	logic [7:0]           processor_status_word;
	logic                 nonmaskable_active;
	logic                 irq_level;
	logic [3:0]           delay;
	int                   n_fail;
	int                   checks;
	logic [15:0] prio_vec [7] = '{16'h0004, 16'h000c, 16'h000e, 16'h0010,
		16'h0012, 16'h0014, 16'h0016};
	logic [7:0]  sel_tab [4] = '{8'h00, 8'h3e, 8'h15, 8'h15};
	logic [2:0]  pin_tab [4] = '{3'h0, 3'h7, 3'h0, 3'h7};
	logic        fire_tab [4] = '{1'b1, 1'b1, 1'b0, 1'b1};

	prioritized_vectored_interrupts dut_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req),
		.reg_rdata(reg_rdata), .periph_evt(periph_evt),
		.ext_edge_irqs(ext_edge_irqs), .key_return_n(key_return_n),
		.core_ctl(core_ctl), .irq_req(irq_req), .irq_vector(irq_vector),
		.nmi_req(nmi_req), .processor_status_word(processor_status_word),
		.nonmaskable_active(nonmaskable_active), .irq_level(irq_level));

	pvi_core_model core_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .irq_req(irq_req),
		.nmi_req(nmi_req), .processor_status_word(processor_status_word),
		.delay(delay), .core_ctl(core_ctl));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// Strobe, then one idle cycle so no signal is set twice per step
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk);
		bus_req <= '0;
		@(posedge ref_clk);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk);
		bus_req <= '0;
		@(negedge ref_clk);
		cmp({8'h00, reg_rdata}, {8'h00, exp});
		@(posedge ref_clk);
	endtask : rd

	task automatic evt(input pvi_pkg::periph_evt_t e);
		periph_evt <= e;
		@(posedge ref_clk);
		periph_evt <= '0;
		@(posedge ref_clk);
	endtask : evt

	// Vector is judged in the cycle the core acknowledges
	task automatic take(input logic [15:0] exp);
		int i;
		for (i = 0; i < 200; i++) begin
			@(negedge ref_clk);
			if (core_ctl.irq_ack === 1'b1 || core_ctl.nmi_ack === 1'b1)
				break;
		end
		if (i == 200) begin
			n_fail++;
			$display("[ERR] %0t no acknowledge", $time);
			end_sim;
		end else begin
			cmp(irq_vector, exp);
			@(posedge ref_clk);
		end
	endtask : take

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		bus_req = '0;
		periph_evt = '0;
		ext_edge_irqs = 3'h7;
		key_return_n = 8'hff;
		delay = 4'h0;
		n_fail = 0;
		checks = 0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(negedge ref_clk);
		cmp(irq_vector, 16'h0004);
		cmp({8'h00, processor_status_word}, 16'h0000);
		cmp({13'h0, irq_req, nmi_req, nonmaskable_active}, 16'h0000);
		@(posedge ref_clk);
		rd(4'h2, 8'hff);
		rd(4'h3, 8'h07);
		rd(4'h6, 8'h00);
		rd(4'h8, 8'h00);
		$display("test reset done");
		// All internal sources at once, held off by global enable
		wr(4'h2, 8'h00);
		wr(4'h3, 8'h00);
		evt('1);
		repeat (4) @(negedge ref_clk);
		cmp({15'h0, irq_req}, 16'h0000);
		cmp({15'h0, irq_level}, 16'h0001);
		@(posedge ref_clk);
		wr(4'h6, 8'h80);
		for (int k = 0; k < 7; k++)
			take(prio_vec[k]);
		repeat (12) @(posedge ref_clk);
		rd(4'h6, 8'h80);
		$display("test priority done");
		// Slow core; every edge select code on the pins
		delay <= 4'h7;
		for (int k = 0; k < 4; k++) begin
			wr(4'h4, sel_tab[k]);
			ext_edge_irqs <= pin_tab[k];
			if (fire_tab[k]) begin
				take(16'h0006);
				take(16'h0008);
				take(16'h000a);
			end else begin
				repeat (8) @(negedge ref_clk);
				cmp({14'h0, irq_req, irq_level}, 16'h0000);
				@(posedge ref_clk);
			end
		end
		wr(4'h5, 8'h01);
		key_return_n <= 8'hfe;
		take(16'h0018);
		@(negedge ref_clk);
		cmp({8'h00, processor_status_word}, 16'h0000);
		@(posedge ref_clk);
		$display("test pins done");
		wr(4'h7, 8'h01);
		evt('{watchdog_overflow_irq: 1'b1, default: 1'b0});
		@(negedge ref_clk);
		cmp({15'h0, nmi_req}, 16'h0001);
		take(16'h0004);
		@(negedge ref_clk);
		cmp({14'h0, nonmaskable_active, nmi_req}, 16'h0002);
		@(posedge ref_clk);
		rd(4'h7, 8'h03);
		repeat (12) @(negedge ref_clk);
		cmp({15'h0, nonmaskable_active}, 16'h0000);
		$display("test nonmaskable done");
		// Masked source keeps its flag but stays quiet
		@(posedge ref_clk);
		wr(4'h7, 8'h00);
		wr(4'h3, 8'h01);
		evt('{timer8_match_irq: 1'b1, default: 1'b0});
		@(negedge ref_clk);
		cmp({14'h0, irq_req, irq_level}, 16'h0000);
		@(posedge ref_clk);
		rd(4'h1, 8'h01);
		wr(4'h1, 8'h01);
		rd(4'h1, 8'h00);
		$display("test mask done");
		end_sim;
	end
endmodule : tb_prioritized_vectored_interrupts
`default_nettype wire
